/* rsc_pkg.sv */
package rsc_pkg;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [15:0] WATCHDOG_SERVICE_OFFSET = 16'h1ff0;
  localparam logic [15:0] RESET_STATUS_OFFSET     = 16'h1ff4;
  localparam logic [15:0] RESET_CONTROL_OFFSET    = 16'h1ff8;
  localparam int          WATCHDOG_CLEAR_POS      = 0;
  localparam logic [2:0]  RESET_CONTROL_RESET     = 3'h7;

  // ------------------------------------------------------------
  // vectors and memory map
  // ------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR_HI = 16'h1ffe;
  localparam logic [15:0] RESET_VECTOR_LO = 16'h1fff;
  localparam logic [15:0] ROM_FIRST       = 16'h1000;
  localparam logic [15:0] ROM_LAST        = 16'h1fff;
  localparam logic [15:0] RAM_FIRST       = 16'h0080;
  localparam logic [15:0] RAM_LAST        = 16'h012f;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS     = 10;
  localparam int POWERUP_CYCLES      = 4064;
  localparam int PIN_LOW_TENTHS      = 15;
  localparam int PIN_LOW_CYCLES      = (PIN_LOW_TENTHS + 9) / 10;
  localparam int PULLDOWN_MIN_CYCLES = 4;
  localparam int USB_SE0_MIN_BITS    = 4;

  // ------------------------------------------------------------
  // reset cause bits in the status register
  // ------------------------------------------------------------
  localparam int CAUSE_POWER    = 0;
  localparam int CAUSE_PIN      = 1;
  localparam int CAUSE_WATCHDOG = 2;
  localparam int CAUSE_LOWVOLT  = 3;
  localparam int CAUSE_ILLEGAL  = 4;
  localparam int CAUSE_USB      = 5;
  localparam int CAUSE_COUNT    = 6;

  typedef enum logic [3:0] {
    RSC_POWERUP = 4'h1,
    RSC_HOLD    = 4'h2,
    RSC_VECTOR  = 4'h4,
    RSC_RUN     = 4'h8
  } rsc_state_e;

endpackage : rsc_pkg

/* rsc_sync_if.sv */
`timescale 1ns/1ps
interface rsc_sync_if;
  logic raw;
  logic level;
  logic held;
  modport sync (input raw, output level, output held);
  modport user (output raw, input level, input held);
endinterface : rsc_sync_if

/* rsc_sync.sv */
`timescale 1ns/1ps
module rsc_sync #(
  parameter int HOLD_CYCLES = 2
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // request
  rsc_sync_if.sync  s
);
  import rsc_pkg::*;

  // ------------------------------------------------------------
  // two flops, then a run-length filter
  // ------------------------------------------------------------
  typedef struct packed {
    logic       m1;
    logic       m2;
    logic [7:0] run;
    logic       held;
  } rsc_sync_s;

  rsc_sync_s st_r;
  rsc_sync_s st_nxt;

  always_comb begin
    st_nxt    = st_r;
    st_nxt.m1 = s.raw;
    st_nxt.m2 = st_r.m1;
    if (!st_r.m2) begin
      st_nxt.run  = 8'h00;
      st_nxt.held = 1'b0;
    end else if (st_r.run < 8'(HOLD_CYCLES - 1)) begin
      st_nxt.run = st_r.run + 8'h01;
    end else begin
      st_nxt.held = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s.level = st_r.m2;
  assign s.held  = st_r.held;

endmodule : rsc_sync

/* rsc_top.sv */
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module rsc_top #(
  parameter int POWERUP_DELAY = rsc_pkg::POWERUP_CYCLES,
  parameter bit WATCHDOG_OPT  = 1'b1,
  parameter bit LOWVOLT_OPT   = 1'b1
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // reset pin, open drain
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_n,
  // analog and timing sources
  input  wire logic        osc_active,
  input  wire logic        power_on_threshold,
  input  wire logic        lowvolt_trip,
  input  wire logic        watchdog_timeout,
  input  wire logic        usb_se0_bit,
  input  wire logic        usb_se0,
  // cpu side
  input  wire logic        opcode_fetch,
  input  wire logic [15:0] fetch_addr,
  output logic             internal_reset,
  output logic             abort_instr,
  output logic [15:0]      vector_addr,
  output logic             vector_fetch,
  output logic             set_irq_mask,
  output logic             watchdog_restart,
  output logic             bus_reset_flag
);
  import rsc_pkg::*;

  // ------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------
  rsc_sync_if pin_if ();
  rsc_sync_if lvd_if ();
  rsc_sync_if osc_if ();
  rsc_sync_if por_if ();

  assign pin_if.raw = ~reset_pin_in;
  assign lvd_if.raw = lowvolt_trip;
  assign osc_if.raw = osc_active;
  assign por_if.raw = power_on_threshold;

  rsc_sync #(.HOLD_CYCLES(PIN_LOW_CYCLES)) u_pin_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (pin_if.sync)
  );
  rsc_sync #(.HOLD_CYCLES(1)) u_lvd_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (lvd_if.sync)
  );
  rsc_sync #(.HOLD_CYCLES(1)) u_osc_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (osc_if.sync)
  );
  rsc_sync #(.HOLD_CYCLES(1)) u_por_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .s       (por_if.sync)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    rsc_state_e                st;
    logic [12:0]               por_cnt;
    logic                      por_armed;
    logic                      por_active;
    logic [2:0]                pd_cnt;
    logic                      pd_on;
    logic [1:0]                pd_tail;
    logic [3:0]                se0_cnt;
    logic                      usb_det;
    logic                      flag;
    logic                      wd_pend;
    logic                      wd_clear;
    logic                      ill_pend;
    logic [CAUSE_COUNT-1:0]    cause;
    logic [2:0]                ctrl;
    logic                      restart;
    logic                      vec;
    logic [31:0]               rdata;
  } rsc_top_s;

  rsc_top_s r_r;
  rsc_top_s r_nxt;

  logic apb_wr;
  logic apb_rd;
  logic fetch_bad;
  logic pin_src;
  logic any_cause;
  logic drive_src;
  logic wd_en;
  logic lv_en;

  assign apb_wr    = psel && penable && pwrite;
  // read data is fetched in the setup cycle so it stands while pready is high
  assign apb_rd    = psel && !penable && !pwrite;
  assign wd_en     = WATCHDOG_OPT && r_r.ctrl[0];
  assign lv_en     = LOWVOLT_OPT && r_r.ctrl[1];
  assign fetch_bad = opcode_fetch && r_r.st == RSC_RUN
                     && !(fetch_addr >= ROM_FIRST && fetch_addr <= ROM_LAST)
                     && !(fetch_addr >= RAM_FIRST && fetch_addr <= RAM_LAST);
  // our own pulldown echoes through the pin filter; that is no external request
  assign pin_src   = pin_if.held && !r_r.pd_on && r_r.pd_tail == 2'h0;
  // sources that own the pulldown
  assign drive_src = (wd_en && watchdog_timeout && !r_r.wd_clear)
                     || (lv_en && lvd_if.level) || fetch_bad;
  // pending marks only feed the cause bits: the pulldown already stretches
  // those resets, and waiting on the marks would never let reset go
  assign any_cause = pin_src || drive_src || r_r.usb_det || r_r.pd_on;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_nxt         = r_r;
    r_nxt.restart = 1'b0;
    r_nxt.vec     = 1'b0;
    r_nxt.rdata   = 32'h0000_0000;
    // power-on rearm needs a drop below threshold first
    if (!por_if.level) begin
      r_nxt.por_armed = 1'b1;
    end else if (r_r.por_armed) begin
      r_nxt.por_armed  = 1'b0;
      r_nxt.por_active = 1'b1;
      r_nxt.por_cnt    = 13'h0;
      r_nxt.st         = RSC_POWERUP;
    end
    // bus single-ended zero run length
    if (!usb_se0) begin
      r_nxt.se0_cnt = 4'h0;
      r_nxt.usb_det = 1'b0;
    end else if (usb_se0_bit) begin
      if (r_r.se0_cnt < 4'(USB_SE0_MIN_BITS - 1)) begin
        r_nxt.se0_cnt = r_r.se0_cnt + 4'h1;
      end else begin
        r_nxt.usb_det = 1'b1;
        r_nxt.flag    = 1'b1;
      end
    end
    // watchdog pending until the hold state releases reset
    if (wd_en && watchdog_timeout && !r_r.wd_clear) begin
      r_nxt.wd_pend = 1'b1;
    end
    if (fetch_bad) begin
      r_nxt.ill_pend = 1'b1;
    end
    // pulldown: at least the minimum, longer if the source stays
    if (drive_src && !pin_if.level && !r_r.pd_on) begin
      r_nxt.pd_on  = 1'b1;
      r_nxt.pd_cnt = 3'h0;
    end else if (r_r.pd_on) begin
      if (r_r.pd_cnt < 3'(PULLDOWN_MIN_CYCLES - 1)) begin
        r_nxt.pd_cnt = r_r.pd_cnt + 3'h1;
      end else if (!drive_src) begin
        r_nxt.pd_on = 1'b0;
      end
    end
    // two sync flops plus the filter flop: the echo lasts three cycles
    if (r_r.pd_on) begin
      r_nxt.pd_tail = 2'h3;
    end else if (r_r.pd_tail != 2'h0) begin
      r_nxt.pd_tail = r_r.pd_tail - 2'h1;
    end
    // software access
    r_nxt.wd_clear = 1'b0;
    if (apb_wr && paddr == WATCHDOG_SERVICE_OFFSET && !pwdata[WATCHDOG_CLEAR_POS]) begin
      r_nxt.restart  = 1'b1;
      r_nxt.wd_clear = 1'b1;
    end
    if (apb_wr && paddr == RESET_CONTROL_OFFSET) begin
      r_nxt.ctrl = pwdata[2:0];
    end
    if (apb_wr && paddr == RESET_STATUS_OFFSET) begin
      r_nxt.cause = r_r.cause & ~pwdata[CAUSE_COUNT-1:0];
      r_nxt.flag  = r_r.flag & ~pwdata[8];
    end
    if (apb_rd && paddr == RESET_STATUS_OFFSET) begin
      r_nxt.rdata = {19'h0, r_r.st == RSC_RUN, 3'h0, r_r.flag, 2'h0,
                     r_r.cause};
    end else if (apb_rd && paddr == RESET_CONTROL_OFFSET) begin
      r_nxt.rdata = {29'h0, r_r.ctrl};
    end
    // causes set last so a set wins over a clear
    if (r_r.por_active)  r_nxt.cause[CAUSE_POWER]    = 1'b1;
    if (pin_src)         r_nxt.cause[CAUSE_PIN]      = 1'b1;
    if (r_r.wd_pend)     r_nxt.cause[CAUSE_WATCHDOG] = 1'b1;
    if (lv_en && lvd_if.level) r_nxt.cause[CAUSE_LOWVOLT] = 1'b1;
    if (r_r.ill_pend)    r_nxt.cause[CAUSE_ILLEGAL]  = 1'b1;
    if (r_r.usb_det)     r_nxt.cause[CAUSE_USB]      = 1'b1;
    if (r_r.usb_det)     r_nxt.flag = 1'b1;
    // sequencer
    unique case (r_r.st)
      RSC_POWERUP: begin
        if (osc_if.level && !r_nxt.por_armed) begin
          if (r_r.por_cnt < 13'(POWERUP_DELAY - 1)) begin
            r_nxt.por_cnt = r_r.por_cnt + 13'h1;
          end else begin
            r_nxt.por_active = 1'b0;
            r_nxt.st         = RSC_HOLD;
          end
        end
      end
      RSC_HOLD: begin
        if (!any_cause) begin
          r_nxt.st       = RSC_VECTOR;
          r_nxt.wd_pend  = 1'b0;
          r_nxt.ill_pend = 1'b0;
          r_nxt.vec      = 1'b1;
        end
      end
      RSC_VECTOR: begin
        // first cycle fetches the high byte, second the low byte
        if (!r_r.vec) begin
          r_nxt.st = RSC_RUN;
        end
      end
      RSC_RUN: begin
        if (any_cause) begin
          r_nxt.st = RSC_HOLD;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r            <= '0;
      r_r.st         <= RSC_POWERUP;
      r_r.por_active <= 1'b1;
      r_r.ctrl       <= RESET_CONTROL_RESET;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // the watchdog service register reads as zero, so unlisted addresses do too
  assign prdata           = r_r.rdata;
  assign pready           = 1'b1;
  assign pslverr          = 1'b0;
  assign reset_pin_out    = 1'b0;
  assign reset_pin_oe_n   = ~r_r.pd_on;
  assign internal_reset   = r_r.st == RSC_POWERUP || r_r.st == RSC_HOLD;
  assign abort_instr      = internal_reset;
  assign vector_fetch     = r_r.st == RSC_VECTOR;
  assign vector_addr      = r_r.vec ? RESET_VECTOR_HI : RESET_VECTOR_LO;
  assign set_irq_mask     = r_r.vec;
  assign watchdog_restart = r_r.restart;
  assign bus_reset_flag   = r_r.flag;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_pd_min;
    @(posedge pclk) disable iff (!presetn)
    $rose(r_r.pd_on) |-> r_r.pd_on [*4];
  endproperty
  a_pd_min: assert property (p_pd_min) else $error("pulldown shorter than 4");

  property p_pd_reset;
    @(posedge pclk) disable iff (!presetn)
    r_r.pd_on |-> internal_reset || r_r.st == RSC_RUN && any_cause;
  endproperty
  a_pd_reset: assert property (p_pd_reset) else $error("pulldown without reset");

  property p_no_pd_ext;
    @(posedge pclk) disable iff (!presetn)
    $rose(r_r.pd_on) |-> !$past(pin_if.level);
  endproperty
  a_no_pd_ext: assert property (p_no_pd_ext) else $error("pulldown during pin low");

  property p_por_hold;
    @(posedge pclk) disable iff (!presetn)
    r_r.st == RSC_POWERUP |-> internal_reset && r_r.por_cnt < 13'(POWERUP_DELAY);
  endproperty
  a_por_hold: assert property (p_por_hold) else $error("power-up hold broken");

  property p_hold_cause;
    @(posedge pclk) disable iff (!presetn)
    r_r.st == RSC_HOLD && any_cause |=> internal_reset;
  endproperty
  a_hold_cause: assert property (p_hold_cause) else $error("reset left early");

  property p_vector;
    @(posedge pclk) disable iff (!presetn)
    $fell(internal_reset) |-> set_irq_mask && vector_addr == RESET_VECTOR_HI
      ##1 vector_fetch && vector_addr == RESET_VECTOR_LO ##1 r_r.st == RSC_RUN;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector on release");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    apb_wr && paddr == WATCHDOG_SERVICE_OFFSET |=> watchdog_restart == !$past(pwdata[0]);
  endproperty
  a_restart: assert property (p_restart) else $error("service write mishandled");

  property p_illegal;
    @(posedge pclk) disable iff (!presetn)
    fetch_bad && !pin_if.level |=> r_r.pd_on ##1 internal_reset;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal fetch not reset");

  property p_usb;
    @(posedge pclk) disable iff (!presetn)
    r_r.usb_det |=> bus_reset_flag && (internal_reset || r_r.st == RSC_RUN);
  endproperty
  a_usb: assert property (p_usb) else $error("bus reset not flagged");

endmodule : rsc_top

/* rsc_pin_model.sv */
`timescale 1ns/1ps
module rsc_pin_model (
  // request from the bench
  input  wire logic ext_low,
  // device side of the pin
  input  wire logic drv_level,
  input  wire logic drv_oe_n,
  // resolved pin
  output logic      pin_level
);
  // ----------------------------------------
  // open-drain wire with a pull-up
  // ----------------------------------------
  // any party pulling low wins; released, the pull-up brings it high
  assign pin_level = (ext_low || (!drv_oe_n && !drv_level)) ? 1'b0 : 1'b1;
endmodule : rsc_pin_model

/* tb_mcu_reset_source_controller.sv */
`timescale 1ns/1ps
module tb_mcu_reset_source_controller;
  import rsc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int PD = 16;
  logic        pclk, presetn, psel, penable, pwrite;
  logic [15:0] paddr, fetch_addr;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, pin_level, pin_out, oe_n, ext_low;
  logic        osc_active, power_on_threshold, lowvolt_trip, watchdog_timeout;
  logic        usb_se0_bit, usb_se0, opcode_fetch, internal_reset, abort_instr;
  logic [15:0] vector_addr;
  logic        vector_fetch, set_irq_mask, watchdog_restart, bus_reset_flag, wd_seen;
  int          fails, samples_checked, cyc, pd_cnt;
  logic [15:0] ill_addr [8] = '{16'h0080, 16'h012f, 16'h1000, 16'h1fff,
                                16'h007f, 16'h0130, 16'h0fff, 16'h2000};

  rsc_top #(.POWERUP_DELAY(PD)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_in(pin_level), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
    .osc_active(osc_active), .power_on_threshold(power_on_threshold),
    .lowvolt_trip(lowvolt_trip), .watchdog_timeout(watchdog_timeout),
    .usb_se0_bit(usb_se0_bit), .usb_se0(usb_se0), .opcode_fetch(opcode_fetch),
    .fetch_addr(fetch_addr), .internal_reset(internal_reset), .abort_instr(abort_instr),
    .vector_addr(vector_addr), .vector_fetch(vector_fetch), .set_irq_mask(set_irq_mask),
    .watchdog_restart(watchdog_restart), .bus_reset_flag(bus_reset_flag));

  rsc_pin_model i_pin (.ext_low(ext_low), .drv_level(pin_out), .drv_oe_n(oe_n),
                       .pin_level(pin_level));

  // ----------------------------------------
  // clock, timeout, pulldown monitor
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (oe_n === 1'b0) pd_cnt = pd_cnt + 1;
    if (cyc == 20000) begin
      fails = fails + 1;
      wrap_up();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task step();
    @(posedge pclk);
    #1;
  endtask : step

  // apb transfer; read data taken at the edge that sees pready, restart pulse after it
  task apb(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    psel <= 1'b0; penable <= 1'b0;
    #1;
    wd_seen = watchdog_restart;
  endtask : apb

  task wait_rst(input logic v);
    for (int n = 0; n < 60 && internal_reset !== v; n++) step();
    check(internal_reset, v);
    check(abort_instr, v);
  endtask : wait_rst

  // release: two vector fetches from the top of memory, mask set
  task boot();
    for (int n = 0; n < 60 && vector_fetch !== 1'b1; n++) step();
    check(vector_addr, RESET_VECTOR_HI);
    check(set_irq_mask, 1'b1);
    step();
    check({vector_fetch, vector_addr}, {1'b1, RESET_VECTOR_LO});
    wait_rst(1'b0);
  endtask : boot

  task wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    fails = 0; samples_checked = 0; cyc = 0; pd_cnt = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000;
    pwdata = 32'h0; ext_low = 1'b0; osc_active = 1'b1; power_on_threshold = 1'b1;
    lowvolt_trip = 1'b0; watchdog_timeout = 1'b0; usb_se0_bit = 1'b0; usb_se0 = 1'b0;
    opcode_fetch = 1'b0; fetch_addr = 16'h1000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (15) step();
    check(internal_reset, 1'b1);
    boot();
    check(pd_cnt, 0);
    apb(WATCHDOG_SERVICE_OFFSET, 1'b1, 32'h000000fe);
    check(wd_seen, 1'b1);
    apb(WATCHDOG_SERVICE_OFFSET, 1'b1, 32'h00000001);
    check(wd_seen, 1'b0);
    apb(WATCHDOG_SERVICE_OFFSET, 1'b0, 32'h0);
    check(r, 32'h0);
    apb(16'h1ffc, 1'b0, 32'h0);
    check(r, 32'h0);
    check(pslverr, 1'b0);
    // watchdog expiry pulls the pin for the four-cycle minimum
    pd_cnt = 0;
    @(posedge pclk) watchdog_timeout <= 1'b1;
    @(posedge pclk) watchdog_timeout <= 1'b0;
    wait_rst(1'b1);
    boot();
    check(pd_cnt >= 4, 1'b1);
    check(pin_out, 1'b0);
    // watchdog switched off: expiry is ignored
    apb(RESET_CONTROL_OFFSET, 1'b1, 32'h6);
    apb(RESET_CONTROL_OFFSET, 1'b0, 32'h0);
    check(r, 32'h00000006);
    @(posedge pclk) watchdog_timeout <= 1'b1;
    @(posedge pclk) watchdog_timeout <= 1'b0;
    repeat (10) step();
    check(internal_reset, 1'b0);
    apb(RESET_CONTROL_OFFSET, 1'b1, 32'h7);
    // low supply held longer than the minimum pulldown
    pd_cnt = 0;
    @(posedge pclk) lowvolt_trip <= 1'b1;
    repeat (12) @(posedge pclk);
    lowvolt_trip <= 1'b0;
    boot();
    check(pd_cnt >= 10, 1'b1);
    for (int i = 0; i < 8; i++) begin
      pd_cnt = 0;
      @(posedge pclk) begin opcode_fetch <= 1'b1; fetch_addr <= ill_addr[i]; end
      @(posedge pclk) opcode_fetch <= 1'b0;
      repeat (2) step();
      check(internal_reset, i > 3);
      if (i > 3) begin
        boot();
        check(pd_cnt >= 4, 1'b1);
      end
    end
    // pin held low from outside: reset lasts until it rises, no pulldown
    pd_cnt = 0;
    @(posedge pclk) ext_low <= 1'b1;
    repeat (20) step();
    check(internal_reset, 1'b1);
    @(posedge pclk) ext_low <= 1'b0;
    boot();
    check(pd_cnt, 0);
    // three bit times of single-ended zero are too few, four reset
    for (int k = 3; k < 5; k++) begin
      @(posedge pclk) usb_se0 <= 1'b1;
      repeat (k) begin
        @(posedge pclk) usb_se0_bit <= 1'b1;
        @(posedge pclk) usb_se0_bit <= 1'b0;
        repeat (2) @(posedge pclk);
      end
      repeat (4) step();
      check(internal_reset, k == 4);
      @(posedge pclk) usb_se0 <= 1'b0;
    end
    check(bus_reset_flag, 1'b1);
    boot();
    // every cause seen so far, the flag and the running bit; then clear the causes and the flag
    apb(RESET_STATUS_OFFSET, 1'b0, 32'h0);
    check(r, 32'h0000113f);
    apb(RESET_STATUS_OFFSET, 1'b1, 32'h0000013f);
    apb(RESET_STATUS_OFFSET, 1'b0, 32'h0);
    check(r, 32'h00001000);
    check(bus_reset_flag, 1'b0);
    // power-up with the pin still held low at the end of the count
    @(posedge pclk) begin presetn <= 1'b0; ext_low <= 1'b1; end
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (PD + 20) step();
    check(internal_reset, 1'b1);
    @(posedge pclk) ext_low <= 1'b0;
    boot();
    wrap_up();
  end
endmodule : tb_mcu_reset_source_controller
